// file: verif/testbench.sv
`timescale 1ns/1ns
`include "wel_map.svh"
module testbench;
    import wel_pkg::*;
    logic clk;
    logic reset;
    logic cs_n;
    logic sck;
    logic si;
    logic write_enable_latch_ff;
    wel_byte_type status_byte_ff;
    logic array_write_strobe_ff;
    wel_addr_type array_addr_ff;
    wel_byte_type array_data_ff;
    logic write_refused_ff;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int refusals = 0;
    wel_addr_type seen_addr[$];
    wel_byte_type seen_data[$];

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    wel_spi_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));
    wel_latch_top uut (
        .clk(clk),
        .reset(reset),
        .cs_n(cs_n),
        .sck(sck),
        .si(si),
        .write_enable_latch_ff(write_enable_latch_ff),
        .status_byte_ff(status_byte_ff),
        .array_write_strobe_ff(array_write_strobe_ff),
        .array_addr_ff(array_addr_ff),
        .array_data_ff(array_data_ff),
        .write_refused_ff(write_refused_ff)
    );

    // ****************************************
    // Monitor and helpers
    // ****************************************
    always @(posedge clk) begin
        cycles++;
        if (array_write_strobe_ff === 1'b1) begin
            seen_addr.push_back(array_addr_ff);
            seen_data.push_back(array_data_ff);
        end
        if (write_refused_ff === 1'b1) begin
            refusals++;
        end
        // Whole run needs about 2400 cycles
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] expd);
        checks_done++;
        if (seen !== expd) begin
            errors++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic check_flag(input logic expd);
        check(16'(write_enable_latch_ff), 16'(expd));
        check(16'(status_byte_ff), expd ? 16'h0002 : 16'h0000);
    endtask
    task automatic check_byte(input int i, input wel_addr_type a, input wel_byte_type d);
        check(16'(seen_addr[i]), 16'(a));
        check(16'(seen_data[i]), 16'(d));
    endtask
    task automatic send(input int n, input wel_byte_type b0, input wel_byte_type b1,
                        input wel_byte_type b2, input wel_byte_type b3);
        seen_addr.delete();
        seen_data.delete();
        host.frame_begin();
        host.put_byte(b0);
        if (n > 1) host.put_byte(b1);
        if (n > 2) host.put_byte(b2);
        if (n > 3) host.put_byte(b3);
        host.frame_end();
    endtask
    task automatic set_permit();
        send(1, `WEL_OP_SET_PERMIT, 8'h00, 8'h00, 8'h00);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_refused();
        send(3, `WEL_OP_WRITE_LO, 8'h10, 8'h55, 8'h00);
        check(16'(refusals), 16'h0001);
        check(16'(seen_addr.size()), 16'h0000);
        send(2, `WEL_OP_STATUS_STORE, 8'hFF, 8'h00, 8'h00);
        check(16'(refusals), 16'h0002);
        check_flag(1'b0);
        $display("refused test done");
    endtask
    task automatic t_lower_write();
        set_permit();
        check_flag(1'b1);
        send(4, `WEL_OP_WRITE_LO, 8'hFF, 8'hA5, 8'h5A);
        check(16'(seen_addr.size()), 16'h0002);
        check_byte(0, 9'h0FF, 8'hA5);
        check_byte(1, 9'h100, 8'h5A);
        check_flag(1'b0);
        $display("lower write test done");
    endtask
    task automatic t_upper_write();
        set_permit();
        send(4, `WEL_OP_WRITE_HI, 8'hFF, 8'h3C, 8'hC3);
        check(16'(seen_addr.size()), 16'h0002);
        check_byte(0, 9'h1FF, 8'h3C);
        check_byte(1, 9'h000, 8'hC3);
        check_flag(1'b1);
        send(3, `WEL_OP_WRITE_LO, 8'h20, 8'h99, 8'h00);
        check(16'(seen_addr.size()), 16'h0001);
        check_byte(0, 9'h020, 8'h99);
        check(16'(refusals), 16'h0002);
        check_flag(1'b0);
        $display("upper write test done");
    endtask
    task automatic t_store();
        set_permit();
        send(2, `WEL_OP_STATUS_STORE, 8'hFF, 8'h00, 8'h00);
        check(16'(refusals), 16'h0002);
        check_flag(1'b0);
        $display("status store test done");
    endtask
    task automatic t_clear();
        set_permit();
        send(3, `WEL_OP_WRITE_HI, 8'h00, 8'h77, 8'h00);
        check_flag(1'b1);
        send(1, `WEL_OP_CLEAR_PERMIT, 8'h00, 8'h00, 8'h00);
        check_flag(1'b0);
        send(3, `WEL_OP_WRITE_HI, 8'h01, 8'h66, 8'h00);
        check(16'(refusals), 16'h0003);
        check(16'(seen_addr.size()), 16'h0000);
        $display("clear test done");
    endtask
    task automatic t_mode3_reset();
        host.set_idle_level(1'b1);
        set_permit();
        check_flag(1'b1);
        send(3, `WEL_OP_WRITE_HI, 8'h05, 8'h42, 8'h00);
        check(16'(seen_addr.size()), 16'h0001);
        check_byte(0, 9'h105, 8'h42);
        check_flag(1'b1);
        host.set_idle_level(1'b0);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check_flag(1'b0);
        check(16'(refusals), 16'h0003);
        $display("mode 3 and reset test done");
    endtask

    initial begin
        reset = 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check_flag(1'b0);
        $display("reset test done");
        t_refused();
        t_lower_write();
        t_upper_write();
        t_store();
        t_clear();
        t_mode3_reset();
        end_sim();
    end
endmodule

// file: verif/wel_spi_host.sv
`timescale 1ns/1ns
module wel_spi_host (
    input wire logic clk,
    output logic cs_n,
    output logic sck,
    output logic si
);
    logic in_frame;
    logic idle_bit;
    logic data_bit;
    logic sck_idle;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        in_frame = 1'b0;
        idle_bit = 1'b0;
        data_bit = 1'b0;
        sck_idle = 1'b0;
    end
    // Idle data line toggles so a stale bit never passes for a real one
    always @(posedge clk) begin
        if (!in_frame) begin
            idle_bit <= ~idle_bit;
        end
    end
    assign si = in_frame ? data_bit : idle_bit;
    // Idle clock level picks the mode: low for mode 0, high for mode 3
    task automatic set_idle_level(input logic level);
        @(posedge clk);
        sck_idle <= level;
        sck <= level;
    endtask
    task automatic frame_begin();
        @(posedge clk);
        in_frame <= 1'b1;
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // MSB first; 4 clk per phase so synced edges are never lost
    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk);
            sck <= 1'b0;
            data_bit <= b[i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic frame_end();
        @(posedge clk);
        sck <= sck_idle;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        in_frame <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule

// file: verilog/wel_byte_rx.sv
`timescale 1ns/1ns
`include "wel_map.svh"
module wel_byte_rx #(
    parameter int BYTE_BITS = `WEL_BYTE_BITS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    wel_frame_if.rx bus
);
    import wel_pkg::*;

    generate
        if (BYTE_BITS != 8) begin : g_bad_width
            $error("wel_byte_rx serves 8-bit bytes only");
        end
    endgenerate

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic cs_n_s1_ff, cs_n_s2_ff, sck_s1_ff, sck_s2_ff, si_s1_ff, si_s2_ff;
    logic cs_n_prev_ff, sck_prev_ff;
    logic [6:0] shift_ff;
    logic [2:0] bit_cnt_ff;
    logic byte_valid_ff, frame_end_ff;
    wel_byte_type byte_data_ff;
    wel_index_type index_ff, out_index_ff;
    logic sck_rise;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cs_n_s1_ff <= 1'b1;
            cs_n_s2_ff <= 1'b1;
            sck_s1_ff <= 1'b0;
            sck_s2_ff <= 1'b0;
            si_s1_ff <= 1'b0;
            si_s2_ff <= 1'b0;
        end else begin
            cs_n_s1_ff <= cs_n;
            cs_n_s2_ff <= cs_n_s1_ff;
            sck_s1_ff <= sck;
            sck_s2_ff <= sck_s1_ff;
            si_s1_ff <= si;
            si_s2_ff <= si_s1_ff;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cs_n_prev_ff <= 1'b1;
            sck_prev_ff <= 1'b0;
        end else begin
            cs_n_prev_ff <= cs_n_s2_ff;
            sck_prev_ff <= sck_s2_ff;
        end
    end

    // Modes 0 and 3 both sample on the rising serial clock edge
    assign sck_rise = sck_s2_ff & ~sck_prev_ff & ~cs_n_s2_ff;

    // ****************************************
    // Byte assembly, MSB first
    // ****************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shift_ff <= 7'h00;
            bit_cnt_ff <= 3'h0;
        end else if (cs_n_s2_ff) begin
            bit_cnt_ff <= 3'h0;
        end else if (sck_rise) begin
            shift_ff <= {shift_ff[5:0], si_s2_ff};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            byte_valid_ff <= 1'b0;
            byte_data_ff <= 8'h00;
            out_index_ff <= `WEL_IDX_OPCODE;
        end else begin
            byte_valid_ff <= sck_rise && (bit_cnt_ff == 3'h7);
            if (sck_rise && (bit_cnt_ff == 3'h7)) begin
                byte_data_ff <= {shift_ff, si_s2_ff};
                out_index_ff <= index_ff;
            end
        end
    end

    // Index saturates at the data position so long bursts keep counting as data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            index_ff <= `WEL_IDX_OPCODE;
        end else if (cs_n_s2_ff) begin
            index_ff <= `WEL_IDX_OPCODE;
        end else if (sck_rise && (bit_cnt_ff == 3'h7) && (index_ff != `WEL_IDX_DATA)) begin
            index_ff <= index_ff + 2'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            frame_end_ff <= 1'b0;
        end else begin
            frame_end_ff <= cs_n_s2_ff & ~cs_n_prev_ff;
        end
    end

    assign bus.byte_valid = byte_valid_ff;
    assign bus.byte_data = byte_data_ff;
    assign bus.byte_index = out_index_ff;
    assign bus.frame_end = frame_end_ff;
endmodule

// file: verilog/wel_frame_if.sv
`timescale 1ns/1ns
interface wel_frame_if;
    import wel_pkg::*;
    logic byte_valid;
    wel_byte_type byte_data;
    wel_index_type byte_index;
    logic frame_end;
    modport rx (output byte_valid, output byte_data, output byte_index, output frame_end);
    modport core (input byte_valid, input byte_data, input byte_index, input frame_end);
endinterface

// file: verilog/wel_latch_top.sv
`timescale 1ns/1ns
`include "wel_map.svh"
module wel_latch_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    output logic write_enable_latch_ff,
    output wel_pkg::wel_byte_type status_byte_ff,
    output logic array_write_strobe_ff,
    output wel_pkg::wel_addr_type array_addr_ff,
    output wel_pkg::wel_byte_type array_data_ff,
    output logic write_refused_ff
);
    import wel_pkg::*;

    // ****************************************
    // Serial front end
    // ****************************************
    wel_frame_if frame ();

    wel_byte_rx #(
        .BYTE_BITS(`WEL_BYTE_BITS)
    ) u_rx (
        .clk(clk),
        .reset(reset),
        .cs_n(cs_n),
        .sck(sck),
        .si(si),
        .bus(frame)
    );

    function automatic wel_kind_type classify(input wel_byte_type op);
        if (op == `WEL_OP_SET_PERMIT) begin
            return WEL_KIND_SET;
        end else if (op == `WEL_OP_CLEAR_PERMIT) begin
            return WEL_KIND_CLEAR;
        end else if (op == `WEL_OP_STATUS_STORE) begin
            return WEL_KIND_STORE;
        end else if ((op & `WEL_OP_WRITE_MASK) == `WEL_OP_WRITE_LO) begin
            return WEL_KIND_WRITE;
        end else begin
            return WEL_KIND_NONE;
        end
    endfunction

    // ****************************************
    // Opcode capture
    // ****************************************
    wel_kind_type kind_ff;
    wel_byte_type opcode_ff;
    logic taken_ff;
    wel_addr_type addr_ff;
    logic op_byte, is_writer, nxt_latch;

    assign op_byte = frame.byte_valid && (frame.byte_index == `WEL_IDX_OPCODE);
    assign is_writer = (classify(frame.byte_data) == WEL_KIND_WRITE) ||
                       (classify(frame.byte_data) == WEL_KIND_STORE);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            kind_ff <= WEL_KIND_NONE;
            opcode_ff <= 8'h00;
        end else if (frame.frame_end) begin
            kind_ff <= WEL_KIND_NONE;
            opcode_ff <= 8'h00;
        end else if (op_byte) begin
            kind_ff <= classify(frame.byte_data);
            opcode_ff <= frame.byte_data;
        end
    end

    // A write is accepted only if the latch stood set at its opcode
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            taken_ff <= 1'b0;
        end else if (frame.frame_end) begin
            taken_ff <= 1'b0;
        end else if (op_byte) begin
            taken_ff <= is_writer && write_enable_latch_ff;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            write_refused_ff <= 1'b0;
        end else begin
            write_refused_ff <= op_byte && is_writer && !write_enable_latch_ff;
        end
    end

    // ****************************************
    // Array write path
    // ****************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            addr_ff <= 9'h000;
        end else if (op_byte) begin
            addr_ff <= {frame.byte_data[`WEL_OP_ADDR8_POS], 8'h00};
        end else if (frame.byte_valid && (frame.byte_index == `WEL_IDX_ADDR)) begin
            addr_ff <= {addr_ff[8], frame.byte_data};
        end else if (array_write_strobe_ff) begin
            addr_ff <= addr_ff + 9'h001;
        end
    end

    // Address steps one cycle after the strobe; bytes are far slower than that
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            array_write_strobe_ff <= 1'b0;
            array_addr_ff <= 9'h000;
            array_data_ff <= 8'h00;
        end else begin
            array_write_strobe_ff <= frame.byte_valid && taken_ff &&
                                     (frame.byte_index == `WEL_IDX_DATA) &&
                                     (kind_ff == WEL_KIND_WRITE);
            if (frame.byte_valid && taken_ff && (frame.byte_index == `WEL_IDX_DATA) &&
                (kind_ff == WEL_KIND_WRITE)) begin
                array_addr_ff <= addr_ff;
                array_data_ff <= frame.byte_data;
            end
        end
    end

    // ****************************************
    // Write enable latch
    // ****************************************
    // Status store data is never routed here, but an accepted store still clears the latch at frame end
    always_comb begin
        nxt_latch = write_enable_latch_ff;
        if (frame.frame_end) begin
            if (kind_ff == WEL_KIND_SET) begin
                nxt_latch = 1'b1;
            end else if (kind_ff == WEL_KIND_CLEAR) begin
                nxt_latch = 1'b0;
            end else if (taken_ff && (opcode_ff != `WEL_OP_WRITE_HI)) begin
                nxt_latch = 1'b0;
            end
            // Opcode 0x0A falls through and keeps the latch
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            write_enable_latch_ff <= `WEL_LATCH_RESET;
        end else begin
            write_enable_latch_ff <= nxt_latch;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_byte_ff <= `WEL_STATUS_RESET;
        end else begin
            status_byte_ff <= `WEL_STATUS_RESET;
            status_byte_ff[`WEL_STATUS_LATCH_POS] <= nxt_latch;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence close_s(wel_kind_type k);
        frame.frame_end && (kind_ff == k);
    endsequence

    sequence write_close_s;
        frame.frame_end && taken_ff && (kind_ff inside {WEL_KIND_WRITE, WEL_KIND_STORE});
    endsequence

    sequence store_data_s;
        frame.byte_valid && (kind_ff == WEL_KIND_STORE) && !frame.frame_end;
    endsequence

    set_latch_a: assert property (close_s(WEL_KIND_SET) |=> write_enable_latch_ff ##0
        status_byte_ff[`WEL_STATUS_LATCH_POS])
        else $error("latch not set after set command");

    status_mirror_a: assert property (status_byte_ff ==
        {6'h00, write_enable_latch_ff, 1'b0})
        else $error("status byte does not mirror latch");

    store_keeps_a: assert property (store_data_s |=> $stable(write_enable_latch_ff))
        else $error("status store data changed latch");

    write_clear_a: assert property (write_close_s ##0 (opcode_ff != `WEL_OP_WRITE_HI)
        |=> !write_enable_latch_ff ##1 !write_enable_latch_ff)
        else $error("latch not cleared after write");

    refuse_a: assert property (array_write_strobe_ff |-> $past(taken_ff) &&
        $past(kind_ff == WEL_KIND_WRITE))
        else $error("array write without accepted opcode");

    refuse_flag_a: assert property (op_byte && is_writer && !write_enable_latch_ff
        |=> write_refused_ff ##1 !write_refused_ff)
        else $error("refusal not flagged");

    defect_keep_a: assert property (write_close_s ##0 (opcode_ff == `WEL_OP_WRITE_HI)
        |=> write_enable_latch_ff)
        else $error("upper write cleared latch");

    addr_high_a: assert property (op_byte && (classify(frame.byte_data) == WEL_KIND_WRITE)
        |=> addr_ff[8] == (opcode_ff == `WEL_OP_WRITE_HI))
        else $error("address bit 8 not taken from opcode");

    clear_cmd_a: assert property (close_s(WEL_KIND_CLEAR) |=> !write_enable_latch_ff)
        else $error("latch not cleared by clear command");
endmodule

// file: verilog/wel_map.svh
`ifndef WEL_MAP_SVH
`define WEL_MAP_SVH

// ****************************************
// Opcodes
// ****************************************
`define WEL_OP_SET_PERMIT 8'h06
`define WEL_OP_CLEAR_PERMIT 8'h04
`define WEL_OP_STATUS_STORE 8'h01
`define WEL_OP_WRITE_LO 8'h02
`define WEL_OP_WRITE_HI 8'h0A
`define WEL_OP_WRITE_MASK 8'hF7

// ****************************************
// Field positions and reset values
// ****************************************
`define WEL_OP_ADDR8_POS 3
`define WEL_STATUS_LATCH_POS 1
`define WEL_STATUS_RESET 8'h00
`define WEL_LATCH_RESET 1'b0
`define WEL_BYTE_BITS 8
`define WEL_IDX_OPCODE 2'h0
`define WEL_IDX_ADDR 2'h1
`define WEL_IDX_DATA 2'h2

`endif

// file: verilog/wel_pkg.sv
package wel_pkg;
    typedef logic [7:0] wel_byte_type;
    typedef logic [8:0] wel_addr_type;
    typedef logic [1:0] wel_index_type;
    typedef enum logic [2:0] {
        WEL_KIND_NONE = 3'b000,
        WEL_KIND_SET = 3'b001,
        WEL_KIND_CLEAR = 3'b010,
        WEL_KIND_STORE = 3'b011,
        WEL_KIND_WRITE = 3'b100
    } wel_kind_type;
endpackage
